// File: hw/watchdog_pkg.sv
// Shared constants for the watchdog reset timer
package watchdog_pkg;
   // Register indices (byte address is four times the index)
   localparam logic [15:0] SERVICE_IDX = 16'hffff;
   localparam logic [15:0] CAUSE_IDX = 16'h0010;
   localparam logic [15:0] STATE_IDX = 16'h0011;
   localparam int ADDR_W = 18;
   // Reset cause register fields
   localparam int CAUSE_WD_BIT = 0;
   localparam logic [31:0] CAUSE_RESET = 32'h0000_0000;
   // State register fields
   localparam int STATE_PRESC_LSB = 0;
   localparam int STATE_WD_LSB = 16;
   // Counter geometry
   localparam int PRESC_W = 13;
   localparam int WD_W = 6;
   localparam int PRESC_CLR_LSB = 4;
   localparam int PRESC_CLR_MSB = 12;
   localparam int PRESC_TAP = 12;
   // Timing: clock period in ns, pulse and power-on delay in crystal clock cycles, and counter widths
   localparam int CLK_PERIOD_NS = 50;
   localparam int RST_PULSE_CYC = 32;
   localparam int POR_DELAY_CYC = 4096;
   localparam int PULSE_CNT_W = 6;
   localparam int POR_CNT_W = 13;
   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic HRESP_OKAY = 1'h0;
endpackage : watchdog_pkg

// File: hw/watchdog_reset_timer.sv
// Watchdog reset timer with AHB-Lite register slave
`timescale 1ns/1ps

// Function
// (R1) 6-bit counter advanced by 13-bit prescaler carry
// (R2) Unserviced overflow asserts system reset
// (R3) Any service write restarts timeout period
// (R4) Reset drives pin low 32 cycles, sets flag
// (R5) Service write clears prescaler bits 12..4
// (R6) Service read returns reset vector low byte
// (R7) Prescaler cleared 4096 cycles after power-up
// (R8) Internal reset clears prescaler and watchdog counter
// (R9) Reset vector fetch clears the prescaler
// (R10) Disable input suppresses watchdog reset
// (R11) Never raises an interrupt, only reset
// (R12) Monitor mode with high voltage disables
// (R13) Keeps counting during wait mode
// (R14) Break with high voltage on reset disables
// (R15) Counters run on the crystal clock
// (R16) Disable and mode inputs synchronised first
module watchdog_reset_timer
   import watchdog_pkg::*;
#(
   parameter int TAP = watchdog_pkg::PRESC_TAP
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [7:0] reset_vector_low,
   input wire logic vector_fetch,
   input wire logic internal_reset,
   input wire logic watchdog_disable,
   input wire logic monitor_mode,
   input wire logic break_active,
   input wire logic high_volt_irq_pin,
   input wire logic high_volt_reset_pin,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   output logic watchdog_reset
);
   import watchdog_pkg::*;

   if (TAP < 1 || TAP > PRESC_W - 1)
   begin : g_tap_check
      $error("TAP must lie between 1 and 12");
   end

   localparam logic [PULSE_CNT_W-1:0] PULSE_LAST = PULSE_CNT_W'(RST_PULSE_CYC - 1);
   localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_DELAY_CYC - 1);

   // Bus address phase capture
   logic wr_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [31:0] hrdata_ff;
   logic addr_valid;
   logic [15:0] addr_idx;

   // Counters and control
   logic [PRESC_W-1:0] presc_ff;
   logic [WD_W-1:0] wd_ff;
   logic [PULSE_CNT_W-1:0] pulse_cnt_ff;
   logic pulse_ff;
   logic cause_ff;
   logic [POR_CNT_W-1:0] por_cnt_ff;
   logic por_done_ff;
   logic por_clear;
   logic [4:0] sync1_ff;
   logic [4:0] sync2_ff;
   logic dis_eff;
   logic presc_carry;
   logic overflow;
   logic fire;
   logic svc_write;
   logic cause_clear;

   function automatic logic [15:0] word_index(input logic [ADDR_W-1:0] a);
      word_index = a[ADDR_W-1:2];
   endfunction : word_index

   assign addr_valid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
   assign addr_idx = word_index(haddr[ADDR_W-1:0]);
   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   assign hrdata = hrdata_ff;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_ff <= 1'b0;
         addr_ff <= '0;
      end
      else if (hready)
      begin
         wr_ff <= addr_valid && hwrite;
         addr_ff <= haddr[ADDR_W-1:0];
      end
   end

   // Read data is prepared in the address phase so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata_ff <= 32'h0000_0000;
      end
      else if (addr_valid && !hwrite)
      begin
         hrdata_ff <= 32'h0000_0000;
         if (addr_idx == SERVICE_IDX)
         begin
            hrdata_ff[7:0] <= reset_vector_low; // R6
         end
         else if (addr_idx == CAUSE_IDX)
         begin
            hrdata_ff[CAUSE_WD_BIT] <= cause_ff;
         end
         else if (addr_idx == STATE_IDX)
         begin
            hrdata_ff[STATE_PRESC_LSB +: PRESC_W] <= presc_ff;
            hrdata_ff[STATE_WD_LSB +: WD_W] <= wd_ff;
         end
      end
   end

   assign svc_write = wr_ff && word_index(addr_ff) == SERVICE_IDX; // R3
   assign cause_clear = wr_ff && word_index(addr_ff) == CAUSE_IDX && hwdata[CAUSE_WD_BIT];

   // Two-stage synchronisers for disable, mode and high-voltage inputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync1_ff <= 5'h00;
         sync2_ff <= 5'h00;
      end
      else
      begin
         sync1_ff <= {watchdog_disable, monitor_mode, break_active, high_volt_irq_pin, high_volt_reset_pin}; // R16
         sync2_ff <= sync1_ff;
      end
   end

   // sync2: [4] disable, [3] monitor, [2] break, [1] irq pin hv, [0] reset pin hv
   assign dis_eff = sync2_ff[4] // R10
      || (sync2_ff[3] && (sync2_ff[1] || sync2_ff[0])) // R12
      || (sync2_ff[2] && sync2_ff[0]); // R14

   // Power-on delay before the prescaler is cleared once
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         por_cnt_ff <= '0;
         por_done_ff <= 1'b0;
      end
      else if (!por_done_ff)
      begin
         por_cnt_ff <= por_cnt_ff + POR_CNT_W'(1);
         por_done_ff <= por_cnt_ff == POR_LAST;
      end
   end

   assign por_clear = !por_done_ff && por_cnt_ff == POR_LAST; // R7

   // Prescaler and watchdog counter run every crystal clock, wait mode included
   assign presc_carry = &presc_ff[TAP-1:0]; // R1
   assign overflow = presc_carry && &wd_ff; // R2
   assign fire = overflow && !dis_eff && !pulse_ff; // R10

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         presc_ff <= '0;
      end
      else if (internal_reset || pulse_ff || vector_fetch || por_clear) // R8 R9 R7
      begin
         presc_ff <= '0;
      end
      else if (svc_write)
      begin
         presc_ff <= {{(PRESC_CLR_MSB-PRESC_CLR_LSB+1){1'b0}},
            presc_ff[PRESC_CLR_LSB-1:0] + PRESC_CLR_LSB'(1)}; // R5
      end
      else
      begin
         presc_ff <= presc_ff + PRESC_W'(1); // R15 R13
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wd_ff <= '0;
      end
      else if (internal_reset || pulse_ff || svc_write) // R8 R3
      begin
         wd_ff <= '0;
      end
      else if (presc_carry)
      begin
         wd_ff <= wd_ff + WD_W'(1); // R1
      end
   end

   // Reset pulse: pin driven low for a fixed number of cycles
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pulse_ff <= 1'b0;
         pulse_cnt_ff <= '0;
      end
      else if (fire)
      begin
         pulse_ff <= 1'b1; // R4
         pulse_cnt_ff <= '0;
      end
      else if (pulse_ff)
      begin
         pulse_cnt_ff <= pulse_cnt_ff + PULSE_CNT_W'(1);
         pulse_ff <= pulse_cnt_ff != PULSE_LAST; // R4
      end
   end

   // Reset cause flag: a new watchdog reset wins over a software clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cause_ff <= CAUSE_RESET[CAUSE_WD_BIT];
      end
      else if (fire)
      begin
         cause_ff <= 1'b1; // R4
      end
      else if (cause_clear)
      begin
         cause_ff <= 1'b0;
      end
   end

   // Only a reset leaves the block; there is no interrupt output
   assign reset_pin_out = 1'b0; // R11
   assign reset_pin_oe = pulse_ff;
   assign watchdog_reset = pulse_ff; // R2

   a_pulse_length: assert property (@(posedge hclk) disable iff (!hresetn) // R4
      $rose(reset_pin_oe) |-> ##31 reset_pin_oe ##1 !reset_pin_oe)
      else $error("reset pulse not 32 cycles");

   a_pulse_steady: assert property (@(posedge hclk) disable iff (!hresetn) // R4
      $rose(reset_pin_oe) |-> reset_pin_oe [*8])
      else $error("reset pulse dropped early");

   a_cause_flag: assert property (@(posedge hclk) disable iff (!hresetn) // R4
      $rose(reset_pin_oe) |-> cause_ff)
      else $error("cause flag not set with reset");

   a_overflow_fires: assert property (@(posedge hclk) disable iff (!hresetn) // R2
      overflow && !dis_eff && !reset_pin_oe |=> reset_pin_oe)
      else $error("overflow did not reset");

   a_disable_blocks: assert property (@(posedge hclk) disable iff (!hresetn) // R10
      dis_eff && !reset_pin_oe |=> !reset_pin_oe)
      else $error("reset while disabled");

   a_service_clear: assert property (@(posedge hclk) disable iff (!hresetn) // R5
      svc_write && !internal_reset && !pulse_ff && !vector_fetch && !por_clear
      |=> wd_ff == '0 && presc_ff[PRESC_CLR_MSB:PRESC_CLR_LSB] == '0)
      else $error("service write did not clear counters");

   a_vector_read: assert property (@(posedge hclk) disable iff (!hresetn) // R6
      addr_valid && !hwrite && addr_idx == SERVICE_IDX |=> hrdata == {24'h000000, $past(reset_vector_low)})
      else $error("service read not vector byte");

   a_internal_clear: assert property (@(posedge hclk) disable iff (!hresetn) // R8
      internal_reset |=> wd_ff == '0 && presc_ff == '0)
      else $error("internal reset did not clear");

   a_vector_fetch: assert property (@(posedge hclk) disable iff (!hresetn) // R9
      vector_fetch |=> presc_ff == '0)
      else $error("vector fetch did not clear prescaler");

   a_por_clear: assert property (@(posedge hclk) disable iff (!hresetn) // R7
      $rose(por_done_ff) |-> presc_ff == '0)
      else $error("power-up clear missing");

   a_wd_advance: assert property (@(posedge hclk) disable iff (!hresetn) // R1
      !internal_reset && !pulse_ff && !svc_write && presc_carry |=> wd_ff == $past(wd_ff) + WD_W'(1))
      else $error("watchdog counter missed a prescaler carry");

   a_wd_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R1
      !internal_reset && !pulse_ff && !svc_write && !presc_carry |=> $stable(wd_ff))
      else $error("watchdog counter moved without a carry");

   a_presc_counts: assert property (@(posedge hclk) disable iff (!hresetn) // R15 R13
      !internal_reset && !pulse_ff && !vector_fetch && !por_clear && !svc_write
      |=> presc_ff == $past(presc_ff) + PRESC_W'(1))
      else $error("prescaler did not advance");

   a_pin_low_only: assert property (@(posedge hclk) disable iff (!hresetn) // R4
      reset_pin_oe |-> !reset_pin_out)
      else $error("reset pin driven high");

   a_fire_cause: assert property (@(posedge hclk) disable iff (!hresetn) // R2
      $rose(reset_pin_oe) |-> $past(overflow) && !$past(dis_eff))
      else $error("reset without enabled overflow");

   a_service_low: assert property (@(posedge hclk) disable iff (!hresetn) // R5
      svc_write && !internal_reset && !pulse_ff && !vector_fetch && !por_clear
      |=> presc_ff[PRESC_CLR_LSB-1:0] == $past(presc_ff[PRESC_CLR_LSB-1:0]) + PRESC_CLR_LSB'(1))
      else $error("service write disturbed low prescaler bits");

   a_cause_clear: assert property (@(posedge hclk) disable iff (!hresetn) // R4
      cause_clear && !fire |=> !cause_ff)
      else $error("cause flag not cleared by write");

   a_sync_delay: assert property (@(posedge hclk) disable iff (!hresetn) // R16
      $rose(sync2_ff[4]) |-> $past(watchdog_disable, 2))
      else $error("disable synchroniser out of step");

   a_pulse_count: assert property (@(posedge hclk) disable iff (!hresetn) // R4
      reset_pin_oe && pulse_cnt_ff != PULSE_LAST |=> reset_pin_oe)
      else $error("reset pulse ended before its count");

   a_pulse_clears: assert property (@(posedge hclk) disable iff (!hresetn) // R8
      $fell(reset_pin_oe) |-> wd_ff == '0)
      else $error("watchdog counter not clear after pulse");

   c_timeout: cover property (@(posedge hclk) disable iff (!hresetn) $rose(reset_pin_oe));
   c_vector_fetch: cover property (@(posedge hclk) disable iff (!hresetn) vector_fetch && presc_ff != '0);
   c_service: cover property (@(posedge hclk) disable iff (!hresetn) svc_write && wd_ff != '0);
   c_blocked: cover property (@(posedge hclk) disable iff (!hresetn) overflow && dis_eff);
   c_clear_flag: cover property (@(posedge hclk) disable iff (!hresetn) cause_clear && cause_ff);

endmodule : watchdog_reset_timer

// File: bench/wd_sys_partner.sv
// System reset logic and core vector fetch beside the watchdog reset pin
`timescale 1ns/1ps
module wd_sys_partner
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   output logic vector_fetch,
   output logic [7:0] pulse_len,
   output logic pulse_done
);
   logic pin_level;
   logic [7:0] low_cnt_ff;
   // Pull-up holds the pin high while nobody drives it
   assign pin_level = reset_pin_oe ? reset_pin_out : 1'b1;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         low_cnt_ff <= 8'h00;
         pulse_len <= 8'h00;
         pulse_done <= 1'b0;
         vector_fetch <= 1'b0;
      end
      else if (!pin_level)
      begin
         low_cnt_ff <= low_cnt_ff + 8'h01;
         pulse_done <= 1'b0;
         vector_fetch <= 1'b0;
      end
      else
      begin
         pulse_len <= low_cnt_ff;
         pulse_done <= (low_cnt_ff != 8'h00);
         vector_fetch <= (low_cnt_ff != 8'h00);
         low_cnt_ff <= 8'h00;
      end
   end
endmodule : wd_sys_partner

// File: bench/watchdog_reset_timer_tb_top.sv
// Self-checking bench for the watchdog reset timer
`timescale 1ns/1ps
module watchdog_reset_timer_tb_top;
   import watchdog_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hresp, hreadyout, vector_fetch, internal_reset, rd_pend;
   logic watchdog_disable, monitor_mode, break_active, high_volt_irq_pin, high_volt_reset_pin;
   logic reset_pin_out, reset_pin_oe, watchdog_reset, pulse_done;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [7:0] reset_vector_low, pulse_len;
   logic [4:0] modes [5] = '{5'h10, 5'h0a, 5'h09, 5'h05, 5'h06};
   logic [31:0] exp_q[$];
   int err_total, comparisons;

   watchdog_reset_timer #(.TAP(4)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .reset_vector_low(reset_vector_low), .vector_fetch(vector_fetch),
      .internal_reset(internal_reset), .watchdog_disable(watchdog_disable), .monitor_mode(monitor_mode),
      .break_active(break_active), .high_volt_irq_pin(high_volt_irq_pin),
      .high_volt_reset_pin(high_volt_reset_pin), .reset_pin_out(reset_pin_out),
      .reset_pin_oe(reset_pin_oe), .watchdog_reset(watchdog_reset));
   wd_sys_partner u_sys (.hclk(hclk), .hresetn(hresetn), .reset_pin_out(reset_pin_out),
      .reset_pin_oe(reset_pin_oe), .vector_fetch(vector_fetch), .pulse_len(pulse_len), .pulse_done(pulse_done));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic take(input logic [31:0] seen);
      if (exp_q.size() == 0)
         check(seen, 32'hffff_ffff);
      else
         check(seen, exp_q.pop_front());
   endtask : take

   // Reads note the expected word, which the monitor takes in the data phase
   task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] data);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= {14'h0000, idx, 2'b00};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= data;
      rd_pend <= !wr;
      if (!wr)
         exp_q.push_back(data);
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_pend <= 1'b0;
   endtask : xfer

   task automatic wait_ovf(input int lo, input int hi);
      int n;
      n = 0;
      exp_q.push_back(32'(RST_PULSE_CYC));
      while (watchdog_reset !== 1'b1 && n < 2000)
      begin
         @(negedge hclk);
         n++;
      end
      check({31'h0, n >= lo && n <= hi}, 32'h1);
      repeat (40) @(posedge hclk);
      xfer(1'b0, CAUSE_IDX, 32'h1);
      xfer(1'b1, CAUSE_IDX, 32'h1);
      xfer(1'b0, CAUSE_IDX, 32'h0);
   endtask : wait_ovf

   task automatic stop_test();
      err_total += exp_q.size();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   always @(posedge hclk)
   begin
      if (rd_pend && hreadyout)
      begin
         take(hrdata);
         check({31'h0, hresp}, {31'h0, HRESP_OKAY});
      end
      if (pulse_done)
         take({24'h0, pulse_len});
   end

   initial
   begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   initial
   begin
      repeat (20000) @(posedge hclk);
      err_total++;
      stop_test();
   end

   initial
   begin
      {hresetn, hsel, hwrite, internal_reset, rd_pend} = '0;
      {watchdog_disable, monitor_mode, break_active, high_volt_irq_pin, high_volt_reset_pin} = '0;
      {haddr, hwdata, htrans} = '0;
      void'($urandom(11872));
      reset_vector_low = 8'($urandom);
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(1'b0, CAUSE_IDX, 32'h0);
      xfer(1'b0, SERVICE_IDX, {24'h0, reset_vector_low});
      xfer(1'b0, 16'h0020, 32'h0);
      xfer(1'b1, SERVICE_IDX, $urandom);
      wait_ovf(1000, 1040);
      $display("test overflow after service done");
      @(posedge hclk);
      internal_reset <= 1'b1;
      @(posedge hclk);
      internal_reset <= 1'b0;
      wait_ovf(1020, 1040);
      $display("test internal reset done");
      repeat (3)
      begin
         xfer(1'b1, SERVICE_IDX, $urandom);
         repeat (700) @(posedge hclk);
      end
      $display("test periodic service done");
      for (int i = 0; i < 5; i++)
      begin
         xfer(1'b1, SERVICE_IDX, $urandom);
         {watchdog_disable, monitor_mode, break_active, high_volt_irq_pin, high_volt_reset_pin} <= modes[i];
         if (i == 4)
            wait_ovf(1000, 1040);
         else
            repeat (1300) @(posedge hclk);
         xfer(1'b1, SERVICE_IDX, $urandom);
         {watchdog_disable, monitor_mode, break_active, high_volt_irq_pin, high_volt_reset_pin} <= 5'h00;
         $display("test disable mode %0d done", i);
      end
      stop_test();
   end
endmodule : watchdog_reset_timer_tb_top
